// ---- pkg/adct_pkg.sv ----
// Purpose: Shared constants for the converter wrap and trigger select block
// Assumes: 32-bit APB data, one aligned word per register
// Notes: Register index times four gives the byte address
package adct_pkg;

    // Register indices, byte address is index * 4
    localparam logic [3:0] IDX_WRAP = 4'h0;
    localparam logic [3:0] IDX_TRIG_SRC = 4'h1;
    localparam logic [3:0] IDX_TRIG_CTRL = 4'h2;
    localparam logic [3:0] IDX_STATUS = 4'h3;
    localparam int ADDR_LSB = 2;
    localparam int IDX_W = 4;

    // Field positions in wrap_channel_control
    localparam int WRAP_LO = 0;
    localparam int WRAP_HI = 3;

    // Field positions in trigger_source_control
    localparam int CH_SEL_LO = 0;
    localparam int CH_SEL_HI = 3;
    localparam int CLASS_BIT = 7;

    // Field positions in the trigger control register
    localparam int MULTI_BIT = 0;
    localparam int ENABLE_BIT = 1;
    localparam int LEVEL_BIT = 2;
    localparam int POL_BIT = 3;
    localparam int START_LO = 4;
    localparam int START_HI = 7;

    // Field positions in the status register
    localparam int ACTIVE_BIT = 0;
    localparam int RSVD_BIT = 1;
    localparam int CUR_LO = 4;
    localparam int CUR_HI = 7;

    // Reset values
    localparam logic [3:0] WRAP_RST = 4'hf;
    localparam logic [3:0] CH_SEL_RST = 4'h0;
    localparam logic CLASS_RST = 1'b0;
    localparam logic [7:0] CTRL_RST = 8'h00;

    // Channel limits
    localparam logic [3:0] CH_ZERO = 4'h0;
    localparam logic [3:0] CH_LAST = 4'hf;
    localparam logic [3:0] WRAP_RESERVED = 4'h0;
    localparam logic [7:0] ONE_HOT_BASE = 8'h01;

endpackage : adct_pkg

// ---- rtl/adct_trig_select.sv ----
// Purpose: Synchronise trigger pins and pick the selected trigger source
// Assumes: All trigger pins are asynchronous to pclk
// Notes: First synchroniser stage feeds only the second
module adct_trig_select #(
    parameter int NUM_AN = 16,
    parameter int NUM_DED = 4,
    parameter bit HAS_DEDICATED = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [NUM_AN-1:0] analog_in,
    input wire logic [NUM_DED-1:0] dedicated_trigger_inputs,
    input wire logic trig_source_class,
    input wire logic [3:0] trig_channel_sel,
    output logic trig_level,
    output logic reserved_code,
    output logic analog_selected
);

    logic [NUM_AN-1:0] an_meta;
    logic [NUM_AN-1:0] an_sync;
    logic [NUM_DED-1:0] ded_meta;
    logic [NUM_DED-1:0] ded_sync;
    wire logic eff_class;
    wire logic ded_level;
    wire logic an_level;

    // Two-stage synchronisers for every pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            an_meta <= '0;
            an_sync <= '0;
            ded_meta <= '0;
            ded_sync <= '0;
        end else begin
            an_meta <= analog_in;
            an_sync <= an_meta;
            ded_meta <= dedicated_trigger_inputs;
            ded_sync <= ded_meta;
        end
    end

    assign eff_class = trig_source_class & HAS_DEDICATED;
    assign an_level = an_sync[trig_channel_sel];
    assign ded_level = ded_sync[trig_channel_sel[1:0]];
    assign reserved_code = eff_class & (trig_channel_sel[3] | trig_channel_sel[2]);
    assign trig_level = eff_class ? ded_level : an_level;
    assign analog_selected = ~eff_class;

endmodule // adct_trig_select

// ---- rtl/adct_trig_detect.sv ----
// Purpose: Turn the selected trigger level into trigger events
// Assumes: Input already synchronised to pclk
// Notes: Level mode fires every cycle the level is active
module adct_trig_detect (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic trig_level,
    input wire logic ext_trigger_enable,
    input wire logic trigger_level_select,
    input wire logic trigger_polarity,
    input wire logic reserved_code,
    output logic trig_event
);

    logic prev_level;
    wire logic active_level;
    wire logic edge_seen;

    // Previous sample always tracks, so enabling gives no stale edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_level <= 1'b0;
        end else begin
            prev_level <= trig_level;
        end
    end

    assign active_level = (trig_level == trigger_polarity);
    assign edge_seen = active_level & (trig_level != prev_level);
    assign trig_event = ext_trigger_enable & ~reserved_code & (trigger_level_select ? active_level : edge_seen);

endmodule // adct_trig_detect

// ---- rtl/adct_wrap_trig.sv ----
// Purpose: Wrap channel and trigger source control with APB registers
// Assumes: Single clock pclk, asynchronous active-low reset presetn
// Notes: Conversion timing is modelled by a cycle count per channel
//
// Overview of operation
// - A four-bit wrap field names the last channel of a multi-channel sequence.
// - In multi-channel mode a wrap value n of 1 to 15 wraps to channel zero after channel n; zero is reserved.
// - Any write to the trigger select register aborts the running sequence and starts none.
// - Bit 7 of trigger select picks analog channels or dedicated trigger inputs.
// - With the class bit clear the channel field routes that analog channel to the trigger path.
// - With the class bit set values 0 to 3 pick dedicated inputs and values with bit 2 or 3 are reserved.
// - Without dedicated inputs the class bit is stored but the analog channel stays the source.
// - The selected trigger starts conversions only while external triggering is enabled.
// - With an analog source and triggering enabled that channel's digital input buffer is enabled.
// - Level-select and polarity give falling edge, rising edge, low level and high level sensitivity.
module adct_wrap_trig #(
    parameter int NUM_AN = 16,
    parameter int NUM_DED = 4,
    parameter bit HAS_DEDICATED = 1'b1,
    parameter int CONV_CYCLES = 14
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_AN-1:0] analog_in,
    input wire logic [NUM_DED-1:0] dedicated_trigger_inputs,
    output logic [NUM_AN-1:0] dig_in_en,
    output logic conv_start,
    output logic [3:0] conv_channel,
    output logic seq_active,
    output logic seq_done
);

    typedef enum logic [0:0] {
        ST_IDLE,
        ST_CONVERT
    } adct_state_t;

    localparam int CNT_W = $clog2(CONV_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CONV_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;

    // Software-visible state
    logic [3:0] wrap_channel;
    logic [3:0] trig_channel_sel;
    logic trig_source_class;
    logic [7:0] trig_ctrl;

    // Sequencer state
    adct_state_t state;
    adct_state_t next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [3:0] next_channel;
    logic next_conv_start;
    logic next_seq_done;

    // Bus decode
    localparam int IDX_W_L = adct_pkg::IDX_W;
    wire logic [IDX_W_L-1:0] idx;
    wire logic setup_access;
    wire logic done_access;
    wire logic wr_done;
    wire logic mapped;
    wire logic abort_wr;
    wire logic [31:0] rd_mux;

    // Control fields
    wire logic multi_channel_mode;
    wire logic ext_trigger_enable;
    wire logic trigger_level_select;
    wire logic trigger_polarity;
    wire logic [3:0] start_channel;
    wire logic [3:0] last_channel;
    wire logic trig_level;
    wire logic reserved_code;
    wire logic analog_selected;
    wire logic trig_event;
    wire logic step_end;
    wire logic more_channels;
    wire logic [NUM_AN-1:0] next_dig_in_en;

    // Decode used by several read and write paths
    function automatic logic idx_is(input logic [IDX_W_L-1:0] a, input logic [3:0] want);
        idx_is = (a == want);
    endfunction

    // APB decode; one wait state keeps read data registered
    assign idx = paddr[adct_pkg::ADDR_LSB +: IDX_W_L];
    assign setup_access = psel & penable & ~pready;
    assign done_access = psel & penable & pready;
    assign wr_done = done_access & pwrite;
    assign mapped = (paddr[31:adct_pkg::ADDR_LSB + IDX_W_L] == '0) & (paddr[adct_pkg::ADDR_LSB-1:0] == '0)
                    & (idx_is(idx, adct_pkg::IDX_WRAP) | idx_is(idx, adct_pkg::IDX_TRIG_SRC)
                    | idx_is(idx, adct_pkg::IDX_TRIG_CTRL) | idx_is(idx, adct_pkg::IDX_STATUS));
    assign abort_wr = wr_done & mapped & ~idx_is(idx, adct_pkg::IDX_STATUS);

    // Read multiplexer, unused upper bits read zero
    assign rd_mux = !mapped ? 32'h0000_0000 :
        idx_is(idx, adct_pkg::IDX_WRAP) ? {28'h000_0000, wrap_channel} :
        idx_is(idx, adct_pkg::IDX_TRIG_SRC) ? {24'h00_0000, trig_source_class, 3'h0, trig_channel_sel} :
        idx_is(idx, adct_pkg::IDX_TRIG_CTRL) ? {24'h00_0000, trig_ctrl} :
        {24'h00_0000, conv_channel, 2'h0, reserved_code, seq_active};

    // Bus answer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= setup_access;
            prdata <= setup_access ? rd_mux : prdata;
            pslverr <= setup_access & ~mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wrap_channel <= adct_pkg::WRAP_RST;
        end else if (wr_done & mapped & idx_is(idx, adct_pkg::IDX_WRAP)) begin
            wrap_channel <= pwdata[adct_pkg::WRAP_HI:adct_pkg::WRAP_LO];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_channel_sel <= adct_pkg::CH_SEL_RST;
            trig_source_class <= adct_pkg::CLASS_RST;
        end else if (wr_done & mapped & idx_is(idx, adct_pkg::IDX_TRIG_SRC)) begin
            trig_channel_sel <= pwdata[adct_pkg::CH_SEL_HI:adct_pkg::CH_SEL_LO];
            trig_source_class <= pwdata[adct_pkg::CLASS_BIT];
        end
    end

    // Trigger control bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_ctrl <= adct_pkg::CTRL_RST;
        end else if (wr_done & mapped & idx_is(idx, adct_pkg::IDX_TRIG_CTRL)) begin
            trig_ctrl <= pwdata[7:0];
        end
    end

    assign multi_channel_mode = trig_ctrl[adct_pkg::MULTI_BIT];
    assign ext_trigger_enable = trig_ctrl[adct_pkg::ENABLE_BIT];
    assign trigger_level_select = trig_ctrl[adct_pkg::LEVEL_BIT];
    assign trigger_polarity = trig_ctrl[adct_pkg::POL_BIT];
    assign start_channel = trig_ctrl[adct_pkg::START_HI:adct_pkg::START_LO];

    // Source selection and synchronisers
    adct_trig_select #(
        .NUM_AN(NUM_AN),
        .NUM_DED(NUM_DED),
        .HAS_DEDICATED(HAS_DEDICATED)
    ) u_select (
        .pclk(pclk),
        .presetn(presetn),
        .analog_in(analog_in),
        .dedicated_trigger_inputs(dedicated_trigger_inputs),
        .trig_source_class(trig_source_class),
        .trig_channel_sel(trig_channel_sel),
        .trig_level(trig_level),
        .reserved_code(reserved_code),
        .analog_selected(analog_selected)
    );

    // Edge or level sensing
    adct_trig_detect u_detect (
        .pclk(pclk),
        .presetn(presetn),
        .trig_level(trig_level),
        .ext_trigger_enable(ext_trigger_enable),
        .trigger_level_select(trigger_level_select),
        .trigger_polarity(trigger_polarity),
        .reserved_code(reserved_code),
        .trig_event(trig_event)
    );

    // digital buffer of the trigger channel
    assign next_dig_in_en = (ext_trigger_enable & analog_selected) ? (NUM_AN'(1) << trig_channel_sel) : '0;

    // reserved zero wraps after the top channel
    assign last_channel = (wrap_channel == adct_pkg::WRAP_RESERVED) ? adct_pkg::CH_LAST : wrap_channel;
    assign step_end = (cnt == CNT_LAST);
    assign more_channels = multi_channel_mode & (conv_channel != last_channel);

    // Sequencer next state; abort beats a trigger in the same cycle
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_channel = conv_channel;
        next_conv_start = 1'b0;
        next_seq_done = 1'b0;
        unique case (state)
            ST_IDLE: begin
                // no start in an abort cycle
                if (trig_event & ~abort_wr) begin
                    next_state = ST_CONVERT;
                    next_cnt = CNT_ZERO;
                    next_channel = multi_channel_mode ? adct_pkg::CH_ZERO : start_channel;
                    next_conv_start = 1'b1;
                end
            end
            ST_CONVERT: begin
                if (abort_wr) begin
                    next_state = ST_IDLE;
                    next_cnt = CNT_ZERO;
                end else if (step_end & more_channels) begin
                    next_cnt = CNT_ZERO;
                    next_channel = conv_channel + 4'h1;
                    next_conv_start = 1'b1;
                end else if (step_end) begin
                    next_state = ST_IDLE;
                    next_cnt = CNT_ZERO;
                    next_channel = multi_channel_mode ? adct_pkg::CH_ZERO : conv_channel;
                    next_seq_done = 1'b1;
                end else begin
                    next_cnt = cnt + CNT_W'(1);
                end
            end
        endcase
    end

    // Sequencer registers and registered outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            cnt <= CNT_ZERO;
            conv_channel <= adct_pkg::CH_ZERO;
            conv_start <= 1'b0;
            seq_done <= 1'b0;
            seq_active <= 1'b0;
            dig_in_en <= '0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            conv_channel <= next_channel;
            conv_start <= next_conv_start;
            seq_done <= next_seq_done;
            seq_active <= (next_state == ST_CONVERT);
            dig_in_en <= next_dig_in_en;
        end
    end

    // Checks
    sequence s_apb_write;
        psel && penable && pready && pwrite && mapped;
    endsequence

    property p_abort_on_write;
        @(posedge pclk) disable iff (!presetn)
        (s_apb_write and (idx == adct_pkg::IDX_TRIG_SRC)) |=> !seq_active && !conv_start;
    endproperty
    a_abort_on_write: assert property (p_abort_on_write) else $error("write did not abort sequence");

    property p_wrap_store;
        @(posedge pclk) disable iff (!presetn)
        (s_apb_write and (idx == adct_pkg::IDX_WRAP)) |=> wrap_channel == $past(pwdata[3:0]);
    endproperty
    a_wrap_store: assert property (p_wrap_store) else $error("wrap field not stored");

    property p_wrap_to_zero;
        @(posedge pclk) disable iff (!presetn)
        (seq_active && multi_channel_mode && step_end && conv_channel == last_channel && !abort_wr)
            |=> !seq_active && seq_done && conv_channel == adct_pkg::CH_ZERO;
    endproperty
    a_wrap_to_zero: assert property (p_wrap_to_zero) else $error("sequence did not wrap");

    property p_class_store;
        @(posedge pclk) disable iff (!presetn)
        (s_apb_write and (idx == adct_pkg::IDX_TRIG_SRC)) |=> trig_source_class == $past(pwdata[7]);
    endproperty
    a_class_store: assert property (p_class_store) else $error("class bit not stored");

    property p_analog_route;
        @(posedge pclk) disable iff (!presetn)
        !trig_source_class |-> trig_level == u_select.an_sync[trig_channel_sel];
    endproperty
    a_analog_route: assert property (p_analog_route) else $error("analog channel not routed");

    property p_reserved_flag;
        @(posedge pclk) disable iff (!presetn)
        (HAS_DEDICATED && trig_source_class && (trig_channel_sel[3] || trig_channel_sel[2])) |-> reserved_code;
    endproperty
    a_reserved_flag: assert property (p_reserved_flag) else $error("reserved code not flagged");

    property p_no_dedicated;
        @(posedge pclk) disable iff (!presetn)
        !HAS_DEDICATED |-> analog_selected && !reserved_code;
    endproperty
    a_no_dedicated: assert property (p_no_dedicated) else $error("class bit acted without inputs");

    sequence s_idle_quiet;
        !seq_active && !ext_trigger_enable;
    endsequence

    property p_disabled_no_start;
        @(posedge pclk) disable iff (!presetn)
        s_idle_quiet |=> !conv_start;
    endproperty
    a_disabled_no_start: assert property (p_disabled_no_start) else $error("start while disabled");

    property p_buffer_enable;
        @(posedge pclk) disable iff (!presetn)
        ##1 dig_in_en == (($past(ext_trigger_enable) && $past(analog_selected))
            ? (NUM_AN'(1) << $past(trig_channel_sel)) : '0);
    endproperty
    a_buffer_enable: assert property (p_buffer_enable) else $error("input buffer enable wrong");

    property p_rising_edge;
        @(posedge pclk) disable iff (!presetn)
        (ext_trigger_enable && !trigger_level_select && trigger_polarity && !reserved_code
            && !seq_active && !abort_wr && $rose(trig_level)) |=> conv_start && seq_active;
    endproperty
    a_rising_edge: assert property (p_rising_edge) else $error("rising edge missed");

    property p_reserved_quiet;
        @(posedge pclk) disable iff (!presetn)
        (reserved_code && !seq_active) |=> !conv_start;
    endproperty
    a_reserved_quiet: assert property (p_reserved_quiet) else $error("reserved code started");

endmodule // adct_wrap_trig

// ---- tb/adct_src_model.sv ----
// Purpose: Trigger source model for the analog and dedicated trigger lines
// Assumes: Lines are comparator levels with no pull, so unselected lines toggle
// Notes: Only the chosen line carries the commanded level
module adct_src_model (
    input wire logic pclk,
    input wire logic sel_ded,
    input wire logic [3:0] sel_idx,
    input wire logic lvl,
    output logic [15:0] analog_in,
    output logic [3:0] dedicated_trigger_inputs
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [19:0] noise = 20'h5a5a5;
    // Pattern moves every cycle, so a wrong route never looks quiet
    always @(posedge pclk) begin
        noise <= {noise[18:0], ~noise[19]};
    end
    always_comb begin
        analog_in = noise[15:0];
        if (!sel_ded) begin
            analog_in[sel_idx] = lvl;
        end
    end
    always_comb begin
        dedicated_trigger_inputs = noise[19:16];
        if (sel_ded && !sel_idx[3] && !sel_idx[2]) begin
            dedicated_trigger_inputs[sel_idx[1:0]] = lvl;
        end
    end
endmodule // adct_src_model

// ---- tb/adct_wrap_trig_tb_top.sv ----
// Purpose: Self-checking bench for the wrap and trigger select block
// Assumes: APB slave answers with one wait state, short conversion count
// Notes: Expected channel lists come from a queue model in the bench
module adct_wrap_trig_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CONV = 2;
    localparam int WIN = 80;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] analog_in;
    logic [3:0] dedicated_trigger_inputs;
    logic [15:0] dig_in_en;
    logic [15:0] dig_in_en_nd;
    logic conv_start;
    logic [3:0] conv_channel;
    logic seq_active;
    logic seq_done;
    logic sel_ded = 1'b0;
    logic [3:0] sel_idx = 4'h0;
    logic lvl = 1'b0;
    logic [7:0] lfsr = 8'h60;
    int failures = 0;
    int cmp_count = 0;
    int done_count = 0;
    logic [3:0] seen_q[$];
    logic [3:0] exp_q[$];
    logic [31:0] rd;
    logic err;

    adct_wrap_trig #(.CONV_CYCLES(CONV)) adct_wrap_trig_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .analog_in(analog_in), .dedicated_trigger_inputs(dedicated_trigger_inputs),
        .dig_in_en(dig_in_en), .conv_start(conv_start), .conv_channel(conv_channel),
        .seq_active(seq_active), .seq_done(seq_done)
    );
    // Copy built without dedicated inputs, so the class bit must never move the source
    adct_wrap_trig #(.CONV_CYCLES(CONV), .HAS_DEDICATED(1'b0)) adct_wrap_trig_nd_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
        .analog_in(analog_in), .dedicated_trigger_inputs(dedicated_trigger_inputs),
        .dig_in_en(dig_in_en_nd), .conv_start(), .conv_channel(),
        .seq_active(), .seq_done()
    );
    adct_src_model adct_src_model_i (
        .pclk(pclk), .sel_ded(sel_ded), .sel_idx(sel_idx), .lvl(lvl),
        .analog_in(analog_in), .dedicated_trigger_inputs(dedicated_trigger_inputs)
    );

    // Free-running clock, 40 ns period
    always #20 pclk = ~pclk;

    // Collect every channel start and completion pulse
    always @(posedge pclk) begin
        if (conv_start === 1'b1) seen_q.push_back(conv_channel);
        if (seq_done === 1'b1) done_count++;
    end

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No cycle count assumed; only the watchdog ends a hung wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp, input logic experr);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
        chk(err, experr);
    endtask

    task automatic seq_exp(input int from, input int to);
        exp_q.delete();
        for (int i = from; i <= to; i++) exp_q.push_back(i[3:0]);
    endtask

    // Configure, fire the chosen line, watch a fixed window, compare
    task automatic run_trig(input logic ded, input logic [3:0] idx, input logic [7:0] ctrl,
                            input logic [3:0] wrap, input int abort_at);
        @(posedge pclk);
        lvl <= ~ctrl[3];
        sel_ded <= ded;
        sel_idx <= idx;
        apb(1'b1, 32'h8, 32'h0);
        apb(1'b1, 32'h0, {28'h0, wrap});
        apb(1'b1, 32'h4, {24'h0, ded, 3'h0, idx});
        apb(1'b1, 32'h8, {24'h0, ctrl});
        repeat (6) @(posedge pclk);
        chk(dig_in_en, (ctrl[1] && !ded) ? 16'h1 << idx : 16'h0);
        chk(dig_in_en_nd, ctrl[1] ? 16'h1 << idx : 16'h0);
        seen_q.delete();
        done_count = 0;
        lvl <= ctrl[3];
        if (abort_at > 0) begin
            repeat (abort_at) @(posedge pclk);
            apb(1'b1, 32'h4, {24'h0, ded, 3'h0, idx});
        end
        repeat (WIN) @(posedge pclk);
        lvl <= ~ctrl[3];
        if (abort_at > 0) begin
            chk(done_count, 0);
            chk(seq_active, 1'b0);
            chk(seen_q.size() < exp_q.size(), 1'b1);
        end else begin
            if (ctrl[2] && exp_q.size() > 0) chk(seen_q.size() > exp_q.size(), 1'b1);
            else chk(seen_q.size(), exp_q.size());
            chk(done_count > 0, exp_q.size() > 0);
            foreach (exp_q[i]) if (i < seen_q.size()) chk(seen_q[i], exp_q[i]);
        end
        $display("test trig ctrl %h src %h done at %0t", ctrl, {ded, idx}, $time);
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Watchdog sized well above the whole sequence of tests
    initial begin
        #(40 * 30000);
        failures++;
        report_and_stop();
    end

    initial begin
        logic [3:0] w;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(32'h0, 32'hf, 1'b0);
        rdchk(32'h4, 32'h0, 1'b0);
        rdchk(32'hc, 32'h0, 1'b0);
        rdchk(32'h10, 32'h0, 1'b1);
        repeat (4) begin
            lfsr = lfsr_next(lfsr);
            apb(1'b1, 32'h0, {24'hff, lfsr});
            rdchk(32'h0, {28'h0, lfsr[3:0]}, 1'b0);
            apb(1'b1, 32'h4, {24'hff, lfsr});
            rdchk(32'h4, {24'h0, lfsr & 8'h8f}, 1'b0);
            apb(1'b1, 32'h10, 32'h0);
            chk(err, 1'b1);
        end
        $display("test registers done at %0t", $time);
        for (int m = 0; m < 4; m++) begin
            lfsr = lfsr_next(lfsr);
            w = 4'(1 + lfsr % 15);
            seq_exp(0, w);
            run_trig(1'b0, lfsr[7:4], {4'h0, m[0], m[1], 2'b11}, w, 0);
        end
        for (int k = 0; k < 4; k++) begin
            lfsr = lfsr_next(lfsr);
            seq_exp(lfsr[7:4], lfsr[7:4]);
            run_trig(1'b1, 4'(k), {lfsr[7:4], 4'b1010}, 4'h3, 0);
        end
        exp_q.delete();
        run_trig(1'b1, 4'h4, 8'h0b, 4'h2, 0);
        run_trig(1'b1, 4'h8, 8'h0f, 4'h2, 0);
        run_trig(1'b0, 4'h5, 8'h09, 4'h2, 0);
        seq_exp(0, 15);
        run_trig(1'b0, 4'hc, 8'h0b, 4'hf, 8);
        report_and_stop();
    end
endmodule // adct_wrap_trig_tb_top
